// ---- misc_config_map.svh ----
// Register offsets, field positions and reset values for the misc configuration bank.
// Assumes inclusion by the design module and the bench; the guard allows both in one run.
`ifndef MISC_CONFIG_MAP_SVH
`define MISC_CONFIG_MAP_SVH

`define OFS_IRQ_ROUTING      8'hC0
`define OFS_FORCED_DSKCHG    8'hC1
`define OFS_FLOPPY_RATE_SHD  8'hC2
`define OFS_SER1_FCR_SHD     8'hC3
`define OFS_SER2_FCR_SHD     8'hC4
`define OFS_FORCED_WRPROT    8'hC5

`define RST_IRQ_ROUTING      8'h00
`define RST_FORCED_DSKCHG    2'h3
`define RST_FORCED_WRPROT    1'h0
`define RST_SHADOW           8'h00

`define BIT_PARALLEL_IRQ     0
`define BIT_SCI_ON_PIN       2
`define BIT_SCI_POLARITY     3
`define BIT_SCI_OPEN_DRAIN   4
`define BIT_PIN_SEL_LO       5
`define BIT_PIN_SEL_HI       6
`define BIT_SMI_ON_PIN       7

`endif

// ---- misc_config_pkg.sv ----
// Types shared by the misc configuration bank.
// Assumes nothing beyond the map header.
package misc_config_pkg;

   typedef enum logic [1:0]
   {
      PIN_POWER_EVENT = 2'h0,
      PIN_SCI         = 2'h1,
      PIN_IRQ9        = 2'h2,
      PIN_RESERVED    = 2'h3
   } shared_pin_sel_t;

   // Register bus request
   typedef struct packed
   {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

   // Floppy drive side signals, active high after the pins are inverted by the caller
   typedef struct packed
   {
      logic step;
      logic sel0;
      logic sel1;
      logic diskChanged;
      logic writeProtect;
      logic ppWriteProtect;
   } floppy_in_t;

   // One open-drain or push-pull pin
   typedef struct packed
   {
      logic out;
      logic oe;
   } pin_drive_t;

endpackage

// ---- superio_misc_config_regs.sv ----
// Chip-level misc configuration bank: interrupt routing, floppy overrides, write-only shadows.
// Assumes a same-clock register master and floppy pins already inverted to active high.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "misc_config_map.svh"

// Functional notes
// - Bit 0 picks serialized (0) or parallel (1) interrupt delivery.
// - Parallel mode disables BIOS buffer; serial pin becomes IRQ15, clock pin IRQ14.
// - Scheme bit never changes control or management interrupt routing.
// - Bit 2: control interrupt in serial frame (0) or on its pin (1).
// - Bit 3: control interrupt active low (0) or active high (1).
// - Bit 4: control interrupt push-pull (0) or open drain (1).
// - Bits 6:5 pick shared pin: power event, control interrupt, IRQ9, reserved.
// - Bit 5 set overrides the control interrupt channel from its select register.
// - Shared pin driver follows chosen function's polarity and driver type.
// - Bit 7: management interrupt in frame slot IRQ2 (0) or on its pin (1).
// - Forced disk-change bits set by writing one, never cleared by host.
// - Step with drive select clears that drive's forced disk-change bit.
// - Disk-change status = sel0&force0 | sel1&force1 | disk-changed input.
// - Forced bit makes disk-changed appear active while its drive is selected.
// - Bit 0 drive 0, bit 1 drive 1; bits 7:2 read zero.
// - Rate shadow: reset 7, power down 6, reserved 5, write_compensation_select 4:2, rate 1:0.
// - Serial 1 shadow: trigger 7:6, reserved 5:4, DMA 3, clears 2:1, enable 0.
// - Serial 2 shadow uses the same layout for the second serial port.
// - Forced write-protect bit 0 makes write-protect active while drive selected.
// - Write-protect override applies to normal and parallel-port floppy inputs.
module superio_misc_config_regs
(
   // Clock and reset
   input  wire logic                       sys_clk,
   input  wire logic                       reset_n,
   // Register port
   input  wire misc_config_pkg::reg_req_t  regReq,
   output var  logic [7:0]                 regRdata,
   // Writes to the write-only originals elsewhere in the chip
   input  wire logic                       rateWr,
   input  wire logic                       ser1FcrWr,
   input  wire logic                       ser2FcrWr,
   input  wire logic [7:0]                 origWdata,
   // Interrupt sources, active high, and the control interrupt channel select
   input  wire logic                       sciEvent,
   input  wire logic                       smiEvent,
   input  wire logic                       powerEvent,
   input  wire logic                       irq9Event,
   input  wire logic                       irq14Event,
   input  wire logic                       irq15Event,
   input  wire logic [3:0]                 sciChannelCfg,
   // Floppy pins, already inverted to active high
   input  wire misc_config_pkg::floppy_in_t floppyPins,
   // Interrupt routing results
   output var  logic                       parallelIrqMode,
   output var  logic                       biosBufferEnable,
   output var  logic                       serialPinIsIrq15,
   output var  logic                       clockPinIsIrq14,
   output var  misc_config_pkg::pin_drive_t irq15Pin,
   output var  misc_config_pkg::pin_drive_t irq14Pin,
   output var  logic                       sciInFrame,
   output var  logic                       smiInFrameIrq2,
   output var  logic [3:0]                 sciChannel,
   output var  misc_config_pkg::pin_drive_t sciPin,
   output var  misc_config_pkg::pin_drive_t smiPin,
   output var  misc_config_pkg::pin_drive_t sharedPin,
   // Floppy results, active high
   output var  logic                       diskChangeStatus,
   output var  logic                       diskChangedSeen,
   output var  logic                       writeProtectSeen,
   output var  logic                       ppWriteProtectSeen
);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   misc_config_pkg::floppy_in_t floppyMeta;
   misc_config_pkg::floppy_in_t floppy;

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         floppyMeta <= '0;
         floppy     <= '0;
      end
      else
      begin
         floppyMeta <= floppyPins;
         floppy     <= floppyMeta;
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [7:0] irqRouting;
   logic [1:0] forceChange;
   logic       forceWrProt;
   logic [7:0] rateShadow;
   logic [7:0] ser1Shadow;
   logic [7:0] ser2Shadow;
   logic [1:0] next_forceChange;
   logic [1:0] driveSel;
   logic [1:0] hostSet;

   wire wrRouting = regReq.wr && regReq.addr == `OFS_IRQ_ROUTING;
   wire wrForce   = regReq.wr && regReq.addr == `OFS_FORCED_DSKCHG;
   wire wrWrProt  = regReq.wr && regReq.addr == `OFS_FORCED_WRPROT;

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         irqRouting <= `RST_IRQ_ROUTING;
      else if (wrRouting)
         irqRouting <= regReq.wdata;
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         forceWrProt <= `RST_FORCED_WRPROT;
      else if (wrWrProt)
         forceWrProt <= regReq.wdata[0];
   end

   assign driveSel = {floppy.sel1, floppy.sel0};
   assign hostSet  = wrForce ? regReq.wdata[1:0] : 2'h0;

   // Per-drive forced change: host set wins over a simultaneous step clear
   genvar d;
   generate
      for (d = 0; d < 2; d++)
      begin : g_force
         always_comb
         begin
            next_forceChange[d] = forceChange[d];
            if (floppy.step && driveSel[d])
               next_forceChange[d] = 1'b0;
            if (hostSet[d])
               next_forceChange[d] = 1'b1;
         end
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         forceChange <= `RST_FORCED_DSKCHG;
      else
         forceChange <= next_forceChange;
   end

   // Shadows of write-only originals
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rateShadow <= `RST_SHADOW;
         ser1Shadow <= `RST_SHADOW;
         ser2Shadow <= `RST_SHADOW;
      end
      else
      begin
         if (rateWr)
            rateShadow <= origWdata;
         if (ser1FcrWr)
            ser1Shadow <= origWdata;
         if (ser2FcrWr)
            ser2Shadow <= origWdata;
      end
   end

   // ------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         regRdata <= 8'h00;
      else if (regReq.rd)
      begin
         unique case (regReq.addr)
            `OFS_IRQ_ROUTING:     regRdata <= irqRouting;
            `OFS_FORCED_DSKCHG:   regRdata <= {6'h00, forceChange};
            `OFS_FLOPPY_RATE_SHD: regRdata <= rateShadow;
            `OFS_SER1_FCR_SHD:    regRdata <= ser1Shadow;
            `OFS_SER2_FCR_SHD:    regRdata <= ser2Shadow;
            `OFS_FORCED_WRPROT:   regRdata <= {7'h00, forceWrProt};
            default:              regRdata <= 8'h00;
         endcase
      end
      else
         regRdata <= 8'h00;
   end

   // ------------------------------------------------------------
   // Interrupt routing
   // ------------------------------------------------------------
   misc_config_pkg::shared_pin_sel_t pinSel;
   logic sciLevel;
   logic sciOd;
   logic parMode;

   assign pinSel   = misc_config_pkg::shared_pin_sel_t'(irqRouting[`BIT_PIN_SEL_HI:`BIT_PIN_SEL_LO]);
   assign sciLevel = irqRouting[`BIT_SCI_POLARITY] ? sciEvent : !sciEvent;
   assign sciOd    = irqRouting[`BIT_SCI_OPEN_DRAIN];
   assign parMode  = irqRouting[`BIT_PARALLEL_IRQ];

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         parallelIrqMode  <= 1'b0;
         biosBufferEnable <= 1'b1;
         serialPinIsIrq15 <= 1'b0;
         clockPinIsIrq14  <= 1'b0;
         irq15Pin         <= '0;
         irq14Pin         <= '0;
      end
      else
      begin
         parallelIrqMode  <= parMode;
         biosBufferEnable <= !parMode;
         serialPinIsIrq15 <= parMode;
         clockPinIsIrq14  <= parMode;
         irq15Pin         <= '{out: irq15Event, oe: parMode};
         irq14Pin         <= '{out: irq14Event, oe: parMode};
      end
   end

   // Control and management interrupts ignore the scheme bit
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sciInFrame     <= 1'b1;
         smiInFrameIrq2 <= 1'b1;
         sciChannel     <= 4'h0;
         sciPin         <= '0;
         smiPin         <= '0;
      end
      else
      begin
         sciInFrame     <= !irqRouting[`BIT_SCI_ON_PIN];
         smiInFrameIrq2 <= !irqRouting[`BIT_SMI_ON_PIN];
         sciChannel     <= irqRouting[`BIT_PIN_SEL_LO] ? 4'h0 : sciChannelCfg;
         sciPin.out     <= sciLevel && !sciOd;
         sciPin.oe      <= irqRouting[`BIT_SCI_ON_PIN] && (!sciOd || !sciLevel);
         smiPin.out     <= 1'b0;
         smiPin.oe      <= irqRouting[`BIT_SMI_ON_PIN] && smiEvent;
      end
   end

   // Shared pin function and driver
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         sharedPin <= '0;
      else
      begin
         unique case (pinSel)
            misc_config_pkg::PIN_POWER_EVENT: sharedPin <= '{out: 1'b0, oe: powerEvent};
            // Open drain never drives high, so out stays low
            misc_config_pkg::PIN_SCI:         sharedPin <= '{out: sciLevel && !sciOd,
                                                             oe: !sciOd || !sciLevel};
            misc_config_pkg::PIN_IRQ9:        sharedPin <= '{out: irq9Event, oe: 1'b1};
            misc_config_pkg::PIN_RESERVED:    sharedPin <= '0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Floppy overrides
   // ------------------------------------------------------------
   wire forcedSeen = (floppy.sel0 && forceChange[0]) || (floppy.sel1 && forceChange[1]);
   wire wpForce    = forceWrProt && (floppy.sel0 || floppy.sel1);

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         diskChangeStatus   <= 1'b0;
         diskChangedSeen    <= 1'b0;
         writeProtectSeen   <= 1'b0;
         ppWriteProtectSeen <= 1'b0;
      end
      else
      begin
         diskChangeStatus   <= forcedSeen || floppy.diskChanged;
         diskChangedSeen    <= forcedSeen || floppy.diskChanged;
         writeProtectSeen   <= wpForce || floppy.writeProtect;
         ppWriteProtectSeen <= wpForce || floppy.ppWriteProtect;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_host_no_clear;
      @(posedge sys_clk) disable iff (!reset_n)
      wrForce && !floppy.step |=> forceChange == ($past(forceChange) | $past(regReq.wdata[1:0]));
   endproperty
   a_host_no_clear: assert property (p_host_no_clear) else $error("forced change cleared by host");

   property p_step_clear;
      @(posedge sys_clk) disable iff (!reset_n)
      floppy.step && floppy.sel0 && !hostSet[0] |=> !forceChange[0];
   endproperty
   a_step_clear: assert property (p_step_clear) else $error("step did not clear drive 0");

   property p_dskchg;
      @(posedge sys_clk) disable iff (!reset_n)
      forcedSeen |=> diskChangeStatus;
   endproperty
   a_dskchg: assert property (p_dskchg) else $error("disk change status missed force");

   property p_wrprot;
      @(posedge sys_clk) disable iff (!reset_n)
      wpForce |=> writeProtectSeen && ppWriteProtectSeen;
   endproperty
   a_wrprot: assert property (p_wrprot) else $error("write protect not forced");

   sequence s_rate_write;
      rateWr ##1 regReq.rd && regReq.addr == `OFS_FLOPPY_RATE_SHD && !rateWr;
   endsequence
   property p_shadow;
      @(posedge sys_clk) disable iff (!reset_n)
      s_rate_write |=> regRdata == $past(origWdata, 2);
   endproperty
   a_shadow: assert property (p_shadow) else $error("rate shadow readback wrong");

   property p_par_mode;
      @(posedge sys_clk) disable iff (!reset_n)
      ##1 biosBufferEnable == !$past(parMode) && serialPinIsIrq15 == $past(parMode);
   endproperty
   a_par_mode: assert property (p_par_mode) else $error("parallel mode outputs wrong");

   property p_smi_route;
      @(posedge sys_clk) disable iff (!reset_n)
      ##1 smiInFrameIrq2 == !$past(irqRouting[`BIT_SMI_ON_PIN]);
   endproperty
   a_smi_route: assert property (p_smi_route) else $error("management routing wrong");

   property p_irq9;
      @(posedge sys_clk) disable iff (!reset_n)
      pinSel == misc_config_pkg::PIN_IRQ9 |=> sharedPin.oe && sharedPin.out == $past(irq9Event);
   endproperty
   a_irq9: assert property (p_irq9) else $error("shared pin IRQ9 drive wrong");

   property p_reserved_read;
      @(posedge sys_clk) disable iff (!reset_n)
      regReq.rd && regReq.addr == `OFS_FORCED_DSKCHG |=> regRdata[7:2] == 6'h00;
   endproperty
   a_reserved_read: assert property (p_reserved_read) else $error("reserved bits nonzero");

   property p_sci_open_drain;
      @(posedge sys_clk) disable iff (!reset_n)
      sciOd && pinSel == misc_config_pkg::PIN_SCI |=> !sciPin.out && !sharedPin.out;
   endproperty
   a_sci_open_drain: assert property (p_sci_open_drain) else $error("open drain drove high");

   property p_sci_level;
      @(posedge sys_clk) disable iff (!reset_n)
      irqRouting[`BIT_SCI_ON_PIN] && !sciOd && irqRouting[`BIT_SCI_POLARITY] != sciEvent
      |=> sciPin.oe && !sciPin.out;
   endproperty
   a_sci_level: assert property (p_sci_level) else $error("control interrupt level wrong");

   property p_sci_channel;
      @(posedge sys_clk) disable iff (!reset_n)
      irqRouting[`BIT_PIN_SEL_LO] |=> sciChannel == 4'h0;
   endproperty
   a_sci_channel: assert property (p_sci_channel) else $error("channel not overridden");

   property p_pin_reserved;
      @(posedge sys_clk) disable iff (!reset_n)
      pinSel == misc_config_pkg::PIN_RESERVED |=> !sharedPin.oe;
   endproperty
   a_pin_reserved: assert property (p_pin_reserved) else $error("reserved pin select drives");

endmodule // superio_misc_config_regs
`default_nettype wire

// ---- host_bus_model.sv ----
// Host side register master for the misc configuration bank.
// Assumes one clock shared with the bank and read data one cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none

module host_bus_model
(
   // Clock
   input  wire logic                      sys_clk,
   // Register port
   output var  misc_config_pkg::reg_req_t regReq,
   input  wire logic [7:0]                regRdata
);

   initial regReq = '0;

   // ------------------------------------------------------------
   // Bus cycles
   // ------------------------------------------------------------
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      regReq.wr <= 1'b0;
   endtask

   // Data is taken in the one cycle where it stands
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      regReq.rd <= 1'b0;
      #1;
      d = regRdata;
   endtask

endmodule // host_bus_model

`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the misc configuration bank.
// Assumes the host model as register master and floppy pins driven active high.
`timescale 1ns/1ps
`default_nettype none
`include "misc_config_map.svh"

module tb;
   logic                        sys_clk = 1'b0;
   logic                        reset_n = 1'b0;
   misc_config_pkg::reg_req_t   regReq;
   logic [7:0]                  regRdata;
   logic [7:0]                  origWdata = 8'h00;
   logic [7:0]                  rdVal;
   logic                        rateWr = 1'b0, ser1FcrWr = 1'b0, ser2FcrWr = 1'b0;
   logic                        sciEvent = 1'b1, smiEvent = 1'b1, powerEvent = 1'b1, irq9Event = 1'b1;
   logic                        irq14Event = 1'b0, irq15Event = 1'b1;
   logic [3:0]                  sciChannelCfg = 4'h5;
   logic [3:0]                  sciChannel;
   misc_config_pkg::floppy_in_t floppyPins = '0;
   logic                        parallelIrqMode, biosBufferEnable, serialPinIsIrq15, clockPinIsIrq14;
   logic                        sciInFrame, smiInFrameIrq2;
   misc_config_pkg::pin_drive_t irq15Pin, irq14Pin, sciPin, smiPin, sharedPin;
   logic                        diskChangeStatus, diskChangedSeen, writeProtectSeen, ppWriteProtectSeen;
   int                          bad_count = 0;
   int                          checked = 0;
   int                          cycles = 0;
   logic [7:0]                  cfgTab [9] = '{8'h00, 8'h01, 8'h40, 8'h28, 8'h20, 8'h84, 8'h30, 8'h20, 8'h60};
   logic                        evTab  [9] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
   logic [7:0]                  expTab [9] = '{8'h74, 8'h7B, 8'hF4, 8'hF4, 8'h74, 8'h44, 8'h34, 8'hF4, 8'h34};
   logic [7:0]                  pinTab [9] = '{8'h80, 8'hD0, 8'h80, 8'h88, 8'h80, 8'h85, 8'h80, 8'h88, 8'h80};

   always #20 sys_clk = ~sys_clk;

   host_bus_model i_host_bus_model (.sys_clk(sys_clk), .regReq(regReq), .regRdata(regRdata));

   superio_misc_config_regs i_superio_misc_config_regs
   (
      .sys_clk(sys_clk), .reset_n(reset_n), .regReq(regReq), .regRdata(regRdata),
      .rateWr(rateWr), .ser1FcrWr(ser1FcrWr), .ser2FcrWr(ser2FcrWr), .origWdata(origWdata),
      .sciEvent(sciEvent), .smiEvent(smiEvent), .powerEvent(powerEvent), .irq9Event(irq9Event),
      .irq14Event(irq14Event), .irq15Event(irq15Event), .sciChannelCfg(sciChannelCfg),
      .floppyPins(floppyPins), .parallelIrqMode(parallelIrqMode), .biosBufferEnable(biosBufferEnable),
      .serialPinIsIrq15(serialPinIsIrq15), .clockPinIsIrq14(clockPinIsIrq14), .irq15Pin(irq15Pin),
      .irq14Pin(irq14Pin), .sciInFrame(sciInFrame), .smiInFrameIrq2(smiInFrameIrq2),
      .sciChannel(sciChannel), .sciPin(sciPin), .smiPin(smiPin), .sharedPin(sharedPin),
      .diskChangeStatus(diskChangeStatus), .diskChangedSeen(diskChangedSeen),
      .writeProtectSeen(writeProtectSeen), .ppWriteProtectSeen(ppWriteProtectSeen)
   );

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
         bad_count++;
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      i_host_bus_model.read_reg(a, rdVal);
      chk(rdVal, exp);
   endtask

   // Covers the two sync flops plus the output flop
   task automatic settle;
      repeat (4) @(posedge sys_clk);
      #1;
   endtask

   task automatic end_sim;
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         bad_count++;
         end_sim();
      end
   end

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial
   begin
      repeat (6) @(posedge sys_clk);
      reset_n <= 1'b1;
      rd_chk(`OFS_IRQ_ROUTING, 8'h00);
      rd_chk(`OFS_FORCED_DSKCHG, 8'h03);
      rd_chk(`OFS_FORCED_WRPROT, 8'h00);
      rd_chk(8'hC7, 8'h00);
      // Routing table: shared pin, frame routing, scheme, channel override
      for (int i = 0; i < 9; i++)
      begin
         @(posedge sys_clk);
         sciEvent <= evTab[i];
         i_host_bus_model.write_reg(`OFS_IRQ_ROUTING, cfgTab[i]);
         settle();
         chk({sharedPin, sciInFrame, smiInFrameIrq2, parallelIrqMode, biosBufferEnable,
              serialPinIsIrq15, clockPinIsIrq14}, expTab[i]);
         chk({4'h0, sciChannel}, cfgTab[i][5] ? 8'h00 : 8'h05);
         chk({irq15Pin, irq14Pin, sciPin, smiPin}, pinTab[i]);
         rd_chk(`OFS_IRQ_ROUTING, cfgTab[i]);
      end
      i_host_bus_model.write_reg(`OFS_IRQ_ROUTING, 8'h80);
      settle();
      chk({6'h0, smiPin}, 8'h01);
      i_host_bus_model.write_reg(8'hC7, 8'hFF);
      rd_chk(`OFS_IRQ_ROUTING, 8'h80);
      // Forced disk change
      @(posedge sys_clk);
      floppyPins.sel0 <= 1'b1;
      settle();
      chk({6'h0, diskChangeStatus, diskChangedSeen}, 8'h03);
      @(posedge sys_clk);
      floppyPins.step <= 1'b1;
      settle();
      @(posedge sys_clk);
      floppyPins.step <= 1'b0;
      floppyPins.sel0 <= 1'b0;
      rd_chk(`OFS_FORCED_DSKCHG, 8'h02);
      chk({7'h0, diskChangeStatus}, 8'h00);
      @(posedge sys_clk);
      floppyPins.sel1 <= 1'b1;
      settle();
      chk({7'h0, diskChangeStatus}, 8'h01);
      i_host_bus_model.write_reg(`OFS_FORCED_DSKCHG, 8'h00);
      rd_chk(`OFS_FORCED_DSKCHG, 8'h02);
      i_host_bus_model.write_reg(`OFS_FORCED_DSKCHG, 8'hFF);
      rd_chk(`OFS_FORCED_DSKCHG, 8'h03);
      // Forced write protect
      settle();
      chk({6'h0, writeProtectSeen, ppWriteProtectSeen}, 8'h00);
      i_host_bus_model.write_reg(`OFS_FORCED_WRPROT, 8'hFF);
      rd_chk(`OFS_FORCED_WRPROT, 8'h01);
      settle();
      chk({6'h0, writeProtectSeen, ppWriteProtectSeen}, 8'h03);
      // Step on drive 1, then external inputs with no drive selected
      @(posedge sys_clk);
      floppyPins.step <= 1'b1;
      settle();
      @(posedge sys_clk);
      floppyPins.step <= 1'b0;
      floppyPins.sel1 <= 1'b0;
      floppyPins.diskChanged <= 1'b1;
      floppyPins.ppWriteProtect <= 1'b1;
      rd_chk(`OFS_FORCED_DSKCHG, 8'h01);
      settle();
      chk({4'h0, diskChangeStatus, diskChangedSeen, writeProtectSeen, ppWriteProtectSeen}, 8'h0D);
      // Shadows of write-only originals
      @(posedge sys_clk);
      origWdata <= 8'hA5;
      rateWr <= 1'b1;
      // Read the shadow in the cycle right after its capture
      fork
         i_host_bus_model.read_reg(`OFS_FLOPPY_RATE_SHD, rdVal);
         begin
            @(posedge sys_clk);
            rateWr <= 1'b0;
         end
      join
      chk(rdVal, 8'hA5);
      @(posedge sys_clk);
      origWdata <= 8'h5A;
      ser1FcrWr <= 1'b1;
      @(posedge sys_clk);
      ser1FcrWr <= 1'b0;
      origWdata <= 8'hC3;
      ser2FcrWr <= 1'b1;
      @(posedge sys_clk);
      ser2FcrWr <= 1'b0;
      i_host_bus_model.write_reg(`OFS_FLOPPY_RATE_SHD, 8'h00);
      rd_chk(`OFS_FLOPPY_RATE_SHD, 8'hA5);
      rd_chk(`OFS_SER1_FCR_SHD, 8'h5A);
      rd_chk(`OFS_SER2_FCR_SHD, 8'hC3);
      end_sim();
   end

endmodule // tb

`default_nettype wire
